// [core/watchdog_reset_regs.vh]
`ifndef WATCHDOG_RESET_REGS_VH
`define WATCHDOG_RESET_REGS_VH

// ****************
// Register offsets
// ****************
`define ADDR_WDT_CONTROL   8'h00
`define ADDR_RESET_FLAG    8'h01
`define ADDR_STATUS        8'h02
`define ADDR_PORT          8'h03
`define ADDR_CLOCK_OPTION  8'h04

// ****************
// Field positions and reset values
// ****************
`define WDT_CONTROL_RESET  8'h53
`define KEY_MSB            7
`define KEY_LSB            3
`define SEL_MSB            2
`define KEY_DISABLE        5'h15
`define KEY_ENABLE         5'h0a
`define CORRUPT_BIT        0
`define PORT_DATA_BIT      0
`define PORT_DIR_BIT       1
`define FAST_START_BIT     0

// ****************
// Timing
// ****************
// In 10 ns cycles: 50 ms power-on, 16.7 ms reset delay
`define POR_DELAY_CYCLES   24'h4c4b40
`define RESET_DELAY_CYCLES 24'h197b70
`define STARTUP_LAST       10'h3ff
// Bad key resets on the third sub clock edge
`define KEY_FAIL_EDGE      2'h2

`endif

// [core/watchdog_and_reset_control.v]
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "watchdog_reset_regs.vh"

module watchdog_and_reset_control #(
    parameter [23:0] POWER_ON_DELAY = `POR_DELAY_CYCLES,
    parameter [23:0] RESET_DELAY    = `RESET_DELAY_CYCLES
) (
    input  wire       clock,
    input  wire       reset,
    input  wire [7:0] address,
    input  wire [7:0] writeData,
    input  wire       writeStrobe,
    input  wire       readStrobe,
    output reg  [7:0] readData,
    input  wire       lowRcClock,
    input  wire       lowCrystalClock,
    input  wire       subClockSelect,
    input  wire       resetPinEnable,
    input  wire       sharedPinIn,
    output wire       sharedPinOut,
    output wire       sharedPinOe,
    input  wire       clearWatchdogInstr,
    input  wire       haltInstr,
    input  wire       sleepMode,
    input  wire       wakeFromDeepSleep,
    input  wire       wakeFromSubSleep,
    input  wire       highCrystalSystem,
    input  wire       lowVoltDetectEnable,
    output wire       chipReset,
    output reg        pcStackReset,
    output wire       cpuRun,
    output wire       subClockRun,
    output reg        systemClockFromSub,
    output reg        timeoutFlag,
    output reg        powerDownFlag,
    output reg        highOscReady,
    output reg        lowOscReady
);

    // ****************
    // Local states
    // ****************
    localparam [1:0] ST_HOLD = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;
    localparam [1:0] ST_PIN  = 2'h2;

    localparam [1:0] SST_IDLE = 2'h0;
    localparam [1:0] SST_HIGH = 2'h1;
    localparam [1:0] SST_LOW  = 2'h2;

    // ****************
    // Declarations
    // ****************
    wire [2:0]  rawPins;
    reg  [2:0]  syncFirst;
    reg  [2:0]  syncSecond;
    wire        subLevel;
    reg         subPrev;
    wire        subEdge;
    wire        pinLevel;

    reg  [7:0]  wdtControl;
    wire [4:0]  enableKey;
    wire [2:0]  timeoutSelect;
    wire        wdtEnabled;
    wire        keyBad;
    reg  [1:0]  keyFailCount;
    wire        keyFail;
    reg  [17:0] wdtCount;
    wire        tapReached;
    wire        timeoutEvent;
    wire        sleepTimeout;
    wire        normalTimeout;
    wire        fullReset;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [23:0] delayCount;
    reg  [23:0] next_delayCount;

    reg         corruptFlag;
    reg         portData;
    reg         portDirection;
    reg         fastStartEnable;
    reg         waitHigh;

    reg  [1:0]  sstState;
    reg  [9:0]  sstCount;
    reg         pendHigh;
    reg         pendLow;
    wire        sstDone;

    wire        writeAny;
    wire        running;

    // ****************
    // Decode helpers
    // ****************

    // Mask of count bits below the selected tap
    function [17:0] tapMask;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    tapMask = 18'h000ff;
                3'h1:    tapMask = 18'h003ff;
                3'h2:    tapMask = 18'h00fff;
                3'h3:    tapMask = 18'h03fff;
                3'h4:    tapMask = 18'h07fff;
                3'h5:    tapMask = 18'h0ffff;
                3'h6:    tapMask = 18'h1ffff;
                default: tapMask = 18'h3ffff;
            endcase
        end
    endfunction

    // Key is one of the two legal codes
    function keyValid;
        input [4:0] key;
        begin
            keyValid = (key == `KEY_ENABLE) ||
                       (key == `KEY_DISABLE);
        end
    endfunction

    // ****************
    // Pin synchronisers
    // ****************
    assign rawPins = {sharedPinIn, lowCrystalClock, lowRcClock};

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : gSync
            // Two flops per pin; reset pin line resets high
            always @(posedge clock) begin
                if (reset) begin
                    syncFirst[i]  <= (i == 2);
                    syncSecond[i] <= (i == 2);
                end else begin
                    syncFirst[i]  <= rawPins[i];
                    syncSecond[i] <= syncFirst[i];
                end
            end
        end
    endgenerate

    // Sub clock source picked by option
    assign subLevel = subClockSelect ? syncSecond[1]
                                     : syncSecond[0];
    assign pinLevel = syncSecond[2];

    // Rising edge of the sub clock
    always @(posedge clock) begin
        if (reset) begin
            subPrev <= 1'b0;
        end else begin
            subPrev <= subLevel;
        end
    end

    assign subEdge = subLevel & ~subPrev;

    // ****************
    // Watchdog
    // ****************
    assign enableKey     = wdtControl[`KEY_MSB:`KEY_LSB];
    assign timeoutSelect = wdtControl[`SEL_MSB:0];
    assign wdtEnabled    = (enableKey == `KEY_ENABLE);
    assign keyBad        = ~keyValid(enableKey);
    assign running       = (state == ST_RUN);

    // Sub clock stops only with watchdog off and detector off
    assign subClockRun = (enableKey != `KEY_DISABLE) |
                         lowVoltDetectEnable;

    // Bad key fires on third sub edge: 2 to 3 periods
    always @(posedge clock) begin
        if (reset || !keyBad || !running) begin
            keyFailCount <= 2'h0;
        end else if (subEdge) begin
            keyFailCount <= keyFailCount + 2'h1;
        end
    end

    assign keyFail = running & keyBad & subEdge &
                     (keyFailCount == `KEY_FAIL_EDGE);

    // Tap reached on the edge that completes the period
    assign tapReached = &(wdtCount | ~tapMask(timeoutSelect));
    assign timeoutEvent = running & wdtEnabled & subClockRun &
                          subEdge & tapReached;
    assign sleepTimeout  = timeoutEvent & sleepMode;
    assign normalTimeout = timeoutEvent & ~sleepMode;
    assign fullReset     = keyFail | normalTimeout;

    // Watchdog count
    always @(posedge clock) begin
        if (reset || !running) begin
            wdtCount <= 18'h00000;
        end else if (keyFail || clearWatchdogInstr || haltInstr) begin
            wdtCount <= 18'h00000;
        end else if (timeoutEvent) begin
            wdtCount <= 18'h00000;
        end else if (wdtEnabled && subEdge) begin
            wdtCount <= wdtCount + 18'h00001;
        end
    end

    // Pulse that clears program counter and stack in sleep
    always @(posedge clock) begin
        if (reset) begin
            pcStackReset <= 1'b0;
        end else begin
            pcStackReset <= sleepTimeout;
        end
    end

    // ****************
    // Reset sequencer
    // ****************

    // Next state of the reset sequencer
    always @* begin
        next_state      = state;
        next_delayCount = delayCount;
        case (state)
            ST_HOLD: begin
                if (resetPinEnable && !pinLevel) begin
                    next_state = ST_PIN;
                end else if (delayCount == 24'h000000) begin
                    next_state = ST_RUN;
                end else begin
                    next_delayCount = delayCount - 24'h000001;
                end
            end
            ST_RUN: begin
                if (resetPinEnable && !pinLevel) begin
                    next_state = ST_PIN;
                end else if (fullReset) begin
                    next_state      = ST_HOLD;
                    next_delayCount = RESET_DELAY - 24'h000001;
                end
            end
            ST_PIN: begin
                if (!resetPinEnable || pinLevel) begin
                    next_state      = ST_HOLD;
                    next_delayCount = RESET_DELAY - 24'h000001;
                end
            end
            default: begin
                next_state      = ST_HOLD;
                next_delayCount = RESET_DELAY - 24'h000001;
            end
        endcase
    end

    // Sequencer registers
    always @(posedge clock) begin
        if (reset) begin
            state      <= ST_HOLD;
            delayCount <= POWER_ON_DELAY - 24'h000001;
        end else begin
            state      <= next_state;
            delayCount <= next_delayCount;
        end
    end

    // Chip held in reset, program counter forced to zero
    assign chipReset = ~running;
    assign cpuRun    = running & ~waitHigh;

    // ****************
    // Status flags
    // ****************

    // Time-out and power-down flags, set beats clear
    always @(posedge clock) begin
        if (reset) begin
            timeoutFlag   <= 1'b0;
            powerDownFlag <= 1'b0;
        end else begin
            if (timeoutEvent) begin
                timeoutFlag <= 1'b1;
            end else if (running &&
                         (clearWatchdogInstr || haltInstr)) begin
                timeoutFlag <= 1'b0;
            end
            if (running && haltInstr) begin
                powerDownFlag <= 1'b1;
            end else if (running && clearWatchdogInstr) begin
                powerDownFlag <= 1'b0;
            end
        end
    end

    assign writeAny = writeStrobe & running;

    // Corrupt flag: bad key sets, software zero clears
    always @(posedge clock) begin
        if (reset) begin
            corruptFlag <= 1'b0;
        end else if (keyFail) begin
            corruptFlag <= 1'b1;
        end else if (writeAny && address == `ADDR_RESET_FLAG &&
                     !writeData[`CORRUPT_BIT]) begin
            corruptFlag <= 1'b0;
        end
    end

    // ****************
    // Software registers
    // ****************

    // Control, port and clock option registers
    always @(posedge clock) begin
        if (reset || fullReset) begin
            wdtControl      <= `WDT_CONTROL_RESET;
            portData        <= 1'b1;
            portDirection   <= 1'b1;
            fastStartEnable <= 1'b0;
        end else if (writeAny) begin
            case (address)
                `ADDR_WDT_CONTROL: wdtControl <= writeData;
                `ADDR_PORT: begin
                    portData      <= writeData[`PORT_DATA_BIT];
                    portDirection <= writeData[`PORT_DIR_BIT];
                end
                `ADDR_CLOCK_OPTION:
                    fastStartEnable <= writeData[`FAST_START_BIT];
                default: ;
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge clock) begin
        if (reset || !readStrobe) begin
            readData <= 8'h00;
        end else begin
            case (address)
                `ADDR_WDT_CONTROL: readData <= wdtControl;
                `ADDR_RESET_FLAG:  readData <= {7'h00, corruptFlag};
                `ADDR_STATUS:      readData <= {4'h0, lowOscReady,
                                     highOscReady, powerDownFlag,
                                     timeoutFlag};
                `ADDR_PORT:        readData <= {5'h00, pinLevel,
                                     portDirection, portData};
                `ADDR_CLOCK_OPTION:
                    readData <= {7'h00, fastStartEnable};
                default:           readData <= 8'h00;
            endcase
        end
    end

    // Shared pin: reset input or general I/O bit
    assign sharedPinOut = portData;
    assign sharedPinOe  = ~resetPinEnable & ~portDirection;

    // ****************
    // Shared start-up timer
    // ****************
    assign sstDone = (sstState == SST_HIGH &&
                      sstCount == `STARTUP_LAST) ||
                     (sstState == SST_LOW &&
                      (sstCount == `STARTUP_LAST ||
                       !subClockSelect));

    // High crystal served first, low crystal after it
    always @(posedge clock) begin
        if (reset) begin
            sstState     <= SST_IDLE;
            sstCount     <= 10'h000;
            pendHigh     <= 1'b1;
            pendLow      <= 1'b1;
            highOscReady <= 1'b0;
            lowOscReady  <= 1'b0;
        end else begin
            if (wakeFromDeepSleep ||
                (wakeFromSubSleep && highCrystalSystem)) begin
                pendHigh     <= 1'b1;
                highOscReady <= 1'b0;
            end
            if (wakeFromDeepSleep) begin
                pendLow     <= 1'b1;
                lowOscReady <= 1'b0;
            end
            case (sstState)
                SST_IDLE: begin
                    sstCount <= 10'h000;
                    if (pendHigh) begin
                        sstState <= SST_HIGH;
                    end else if (pendLow) begin
                        sstState <= SST_LOW;
                    end
                end
                SST_HIGH: begin
                    sstCount <= sstCount + 10'h001;
                    if (sstDone) begin
                        sstState     <= SST_IDLE;
                        pendHigh     <= 1'b0;
                        highOscReady <= 1'b1;
                    end
                end
                SST_LOW: begin
                    sstCount <= sstCount + 10'h001;
                    if (sstDone) begin
                        sstState    <= SST_IDLE;
                        pendLow     <= 1'b0;
                        lowOscReady <= 1'b1;
                    end
                end
                default: sstState <= SST_IDLE;
            endcase
        end
    end

    // ****************
    // Wake clocking
    // ****************

    // Execution waits for the high oscillator except on a sub wake with fast start or without high crystal system
    always @(posedge clock) begin
        if (reset) begin
            waitHigh <= 1'b1;
        end else if (wakeFromDeepSleep || (wakeFromSubSleep &&
                     highCrystalSystem && !fastStartEnable)) begin
            waitHigh <= 1'b1;
        end else if (highOscReady) begin
            waitHigh <= 1'b0;
        end
    end

    // Fast start runs from the sub clock until high is ready
    always @(posedge clock) begin
        if (reset) begin
            systemClockFromSub <= 1'b0;
        end else if (wakeFromSubSleep && highCrystalSystem &&
                     fastStartEnable) begin
            systemClockFromSub <= 1'b1;
        end else if (highOscReady) begin
            systemClockFromSub <= 1'b0;
        end
    end

endmodule

// [tb/watchdog_reset_checker.sv]
`timescale 1ns/1ps
// ****************
// Port-level checks of the watchdog and reset block
// ****************
module watchdog_reset_checker #(
    parameter [23:0] POWER_ON_DELAY = 24'h000014,
    parameter [23:0] RESET_DELAY    = 24'h00000a
) (
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       readStrobe,
    input wire logic [7:0] readData,
    input wire logic       resetPinEnable,
    input wire logic       sharedPinIn,
    input wire logic       sharedPinOe,
    input wire logic       sleepMode,
    input wire logic       wakeFromDeepSleep,
    input wire logic       lowVoltDetectEnable,
    input wire logic       chipReset,
    input wire logic       pcStackReset,
    input wire logic       cpuRun,
    input wire logic       subClockRun,
    input wire logic       systemClockFromSub,
    input wire logic       timeoutFlag,
    input wire logic       highOscReady,
    input wire logic       lowOscReady
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic [23:0] heldFor;
    logic        ranOnce;

    // Cycles held in reset, and whether the chip has run yet
    always @(posedge clock) begin
        heldFor <= (reset || !chipReset) ? 24'h0 : heldFor + 24'h1;
        ranOnce <= !reset && (ranOnce || !chipReset);
    end

    // Hold, reset and run relations
    a_por_hold: assert property (
        $fell(chipReset) && !ranOnce |-> heldFor >= POWER_ON_DELAY)
        else $error("power-on hold too short");
    a_reset_hold: assert property (
        $fell(chipReset) |-> heldFor >= RESET_DELAY)
        else $error("reset released too early");
    a_pin_reset: assert property (
        (resetPinEnable && !sharedPinIn)[*5] |-> chipReset)
        else $error("low reset pin did not reset");
    a_pin_shared: assert property (
        resetPinEnable && $past(resetPinEnable, 2) |-> !sharedPinOe)
        else $error("reset pin driven as output");
    a_timeout_reset: assert property (
        $rose(timeoutFlag) && !sleepMode |=> chipReset)
        else $error("normal time-out gave no reset");
    a_sleep_wake: assert property (
        pcStackReset |-> timeoutFlag && !chipReset && $past(sleepMode))
        else $error("bad sleep time-out wake");
    a_wake_pulse: assert property (pcStackReset |=> !pcStackReset)
        else $error("counter reset pulse too long");
    a_run_gate: assert property (
        cpuRun |-> (highOscReady || systemClockFromSub) && !chipReset)
        else $error("run without ready oscillator");
    a_deep_wake: assert property (wakeFromDeepSleep |=> !cpuRun)
        else $error("run right after deep wake");
    a_startup_order: assert property (
        $rose(lowOscReady) |-> highOscReady)
        else $error("low ready before high ready");
    a_fast_start: assert property (
        $rose(highOscReady) |=> !systemClockFromSub)
        else $error("sub clock kept after ready");
    a_sub_running: assert property (lowVoltDetectEnable |-> subClockRun)
        else $error("sub clock stopped with detector on");
    a_read_idle: assert property (!$past(readStrobe) |-> readData == 8'h00)
        else $error("read data outside read slot");

    // Main scenarios
    c_normal: cover property ($rose(timeoutFlag) && !sleepMode);
    c_sleep: cover property (pcStackReset);
    c_pin: cover property (resetPinEnable && !sharedPinIn && chipReset);
    c_fast: cover property (systemClockFromSub);
endmodule

bind watchdog_and_reset_control watchdog_reset_checker #(
    .POWER_ON_DELAY(POWER_ON_DELAY), .RESET_DELAY(RESET_DELAY)
) chk (
    .clock(clock), .reset(reset), .readStrobe(readStrobe),
    .readData(readData), .resetPinEnable(resetPinEnable),
    .sharedPinIn(sharedPinIn), .sharedPinOe(sharedPinOe),
    .sleepMode(sleepMode), .wakeFromDeepSleep(wakeFromDeepSleep),
    .lowVoltDetectEnable(lowVoltDetectEnable), .chipReset(chipReset),
    .pcStackReset(pcStackReset), .cpuRun(cpuRun),
    .subClockRun(subClockRun), .systemClockFromSub(systemClockFromSub),
    .timeoutFlag(timeoutFlag), .highOscReady(highOscReady),
    .lowOscReady(lowOscReady)
);

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    // ****************
    // Stimulus and design
    // ****************
    localparam [23:0] POR_D = 24'h000014;
    localparam [23:0] RST_D = 24'h00000a;
    reg         clock;
    reg         reset               = 1'b1;
    reg  [7:0]  address             = 8'h00;
    reg  [7:0]  writeData           = 8'h00;
    reg         writeStrobe         = 1'b0;
    reg         readStrobe          = 1'b0;
    reg         subClockSelect      = 1'b0;
    reg         resetPinEnable      = 1'b0;
    reg         sharedPinIn         = 1'b1;
    reg         sleepMode           = 1'b0;
    reg         highCrystalSystem   = 1'b0;
    reg         lowVoltDetectEnable = 1'b0;
    reg         xtalOn              = 1'b1;
    reg  [3:0]  pulses              = 4'h0;
    reg  [2:0]  subDiv              = 3'h0;
    integer     subEdges            = 0;
    integer     mismatches          = 0;
    integer     checks_done         = 0;
    integer     n;
    integer     e0;
    integer     i;
    reg  [7:0]  d;
    wire [7:0]  readData;
    wire        sharedPinOut, sharedPinOe, chipReset, pcStackReset, cpuRun;
    wire        subClockRun, systemClockFromSub, timeoutFlag, powerDownFlag;
    wire        highOscReady, lowOscReady;
    wire [3:0]  mon = {pcStackReset, timeoutFlag, highOscReady, chipReset};

    watchdog_and_reset_control #(
        .POWER_ON_DELAY(POR_D),
        .RESET_DELAY   (RST_D)
    ) dut (
        .clock(clock), .reset(reset), .address(address),
        .writeData(writeData), .writeStrobe(writeStrobe),
        .readStrobe(readStrobe), .readData(readData),
        .lowRcClock(subDiv[2]), .lowCrystalClock(subDiv[2] & xtalOn),
        .subClockSelect(subClockSelect), .resetPinEnable(resetPinEnable),
        .sharedPinIn(sharedPinIn), .sharedPinOut(sharedPinOut),
        .sharedPinOe(sharedPinOe), .clearWatchdogInstr(pulses[0]),
        .haltInstr(pulses[1]), .sleepMode(sleepMode),
        .wakeFromDeepSleep(pulses[2]), .wakeFromSubSleep(pulses[3]),
        .highCrystalSystem(highCrystalSystem),
        .lowVoltDetectEnable(lowVoltDetectEnable), .chipReset(chipReset),
        .pcStackReset(pcStackReset), .cpuRun(cpuRun),
        .subClockRun(subClockRun), .systemClockFromSub(systemClockFromSub),
        .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag),
        .highOscReady(highOscReady), .lowOscReady(lowOscReady)
    );

    // System clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Free-running sub clock, one period per eight system clocks
    always @(posedge clock) begin
        subDiv <= subDiv + 3'h1;
        if (subDiv == 3'h3) begin
            subEdges <= subEdges + 1;
        end
    end

    // ****************
    // Shared tasks
    // ****************
    task check(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge clock);
            address <= a;
            writeData <= v;
            writeStrobe <= 1'b1;
            @(posedge clock);
            writeStrobe <= 1'b0;
            #1;
        end
    endtask

    task rd(input [7:0] a, output [7:0] v);
        begin
            @(posedge clock);
            address <= a;
            readStrobe <= 1'b1;
            @(posedge clock);
            readStrobe <= 1'b0;
            #1 v = readData;
        end
    endtask

    // Core pulses: 0 clear, 1 halt, 2 deep wake, 3 sub wake
    task pulse(input [1:0] k);
        begin
            @(posedge clock);
            pulses <= 4'h1 << k;
            @(posedge clock);
            pulses <= 4'h0;
            #1;
        end
    endtask

    task wait_sig(input [1:0] k, input v, input integer lim);
        begin
            n = 0;
            while (mon[k] !== v && n < lim) begin
                @(posedge clock);
                #1 n = n + 1;
            end
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_power;
        begin
            wait_sig(0, 1'b0, 100);
            check(n >= POR_D && n <= POR_D + 3, 1);
            check({sharedPinOe, sharedPinOut}, 2'h1);
            rd(8'h00, d);
            check(d, 8'h53);
            rd(8'h03, d);
            check(d, 8'h07);
            rd(8'h01, d);
            check(d, 8'h00);
            rd(8'h10, d);
            check(d, 8'h00);
            check({powerDownFlag, timeoutFlag}, 2'h0);
            wait_sig(1, 1'b1, 1200);
            check(lowOscReady, 1'b0);
            $display("power-on test done");
        end
    endtask

    task t_normal;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                wr(8'h00, 8'h50 | i[7:0]);
                rd(8'h00, d);
                check(d, 8'h50 | i[7:0]);
            end
            subClockSelect <= 1'b1;
            xtalOn <= 1'b0;
            wr(8'h00, 8'h50);
            pulse(0);
            repeat (2200) @(posedge clock);
            #1 check(timeoutFlag, 1'b0);
            xtalOn <= 1'b1;
            pulse(0);
            e0 = subEdges;
            wait_sig(2, 1'b1, 2600);
            check(subEdges - e0 >= 255 && subEdges - e0 <= 257, 1);
            wait_sig(0, 1'b1, 3);
            check(n < 3, 1);
            wait_sig(0, 1'b0, 40);
            check(timeoutFlag, 1'b1);
            rd(8'h00, d);
            check(d, 8'h53);
            $display("normal time-out test done");
        end
    endtask

    task t_sleep;
        begin
            wr(8'h00, 8'h50);
            for (i = 0; i < 5; i = i + 1) begin
                pulse(0);
                repeat (1500) @(posedge clock);
            end
            #1 check({chipReset, timeoutFlag}, 2'h0);
            pulse(1);
            check({powerDownFlag, timeoutFlag}, 2'h2);
            sleepMode <= 1'b1;
            wait_sig(2, 1'b1, 2600);
            check(n > 1900 && n < 2600, 1);
            wait_sig(3, 1'b1, 3);
            check(n < 3, 1);
            check({chipReset, powerDownFlag}, 2'h1);
            rd(8'h02, d);
            check(d, 8'h0f);
            sleepMode <= 1'b0;
            pulse(0);
            check({powerDownFlag, timeoutFlag}, 2'h0);
            $display("sleep time-out test done");
        end
    endtask

    task t_disable;
        begin
            wr(8'h00, 8'ha8);
            check(subClockRun, 1'b0);
            lowVoltDetectEnable <= 1'b1;
            @(posedge clock);
            #1 check(subClockRun, 1'b1);
            lowVoltDetectEnable <= 1'b0;
            repeat (2600) @(posedge clock);
            #1 check({chipReset, timeoutFlag}, 2'h0);
            wr(8'h00, 8'h03);
            wait_sig(0, 1'b1, 40);
            check(n >= 16 && n <= 24, 1);
            wait_sig(0, 1'b0, 40);
            rd(8'h01, d);
            check(d, 8'h01);
            rd(8'h00, d);
            check(d, 8'h53);
            wr(8'h01, 8'hff);
            rd(8'h01, d);
            check(d, 8'h01);
            wr(8'h01, 8'h00);
            rd(8'h01, d);
            check(d, 8'h00);
            $display("key test done");
        end
    endtask

    task t_pin;
        begin
            wr(8'h03, 8'h00);
            check({sharedPinOe, sharedPinOut}, 2'h2);
            rd(8'h03, d);
            check(d, 8'h04);
            wr(8'h03, 8'h03);
            resetPinEnable <= 1'b1;
            sharedPinIn <= 1'b0;
            wait_sig(0, 1'b1, 8);
            check(n < 8, 1);
            repeat (20) @(posedge clock);
            sharedPinIn <= 1'b1;
            wait_sig(0, 1'b0, 40);
            check(n >= RST_D && n <= RST_D + 6, 1);
            $display("pin reset test done");
        end
    endtask

    task t_wake;
        begin
            highCrystalSystem <= 1'b1;
            wr(8'h04, 8'h01);
            pulse(3);
            check(systemClockFromSub, 1'b1);
            wait_sig(1, 1'b1, 1200);
            repeat (2) @(posedge clock);
            #1 check(systemClockFromSub, 1'b0);
            pulse(2);
            check(cpuRun, 1'b0);
            wait_sig(1, 1'b1, 1200);
            check(lowOscReady, 1'b0);
            repeat (2) @(posedge clock);
            #1 check(cpuRun, 1'b1);
            $display("wake test done");
        end
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        t_power;
        t_normal;
        t_sleep;
        t_disable;
        t_pin;
        t_wake;
        stop_test;
    end

    // Watchdog against a hang
    initial begin
        #1000000;
        mismatches = mismatches + 1;
        stop_test;
    end
endmodule
